/* File: hw/cmbf_defs.vh */
// cmbf_defs.vh - constants of the message buffer control flag block
// assumes: included by bare name from hw/ design files
`ifndef CMBF_DEFS_VH
`define CMBF_DEFS_VH
// apb word addresses
`define CMBF_ADDR_CTRL_WR   12'h000
`define CMBF_ADDR_CTRL_RD   12'h004
`define CMBF_ADDR_MODE      12'h008
`define CMBF_ADDR_IRQ_STAT  12'h00c
`define CMBF_ADDR_IRQ_CLR   12'h010
`define CMBF_ADDR_IRQ_EN    12'h014
`define CMBF_ADDR_PAYLOAD   12'h018
// write command bits (clear in low byte, set in high byte)
`define CMBF_CLR_RDY        0
`define CMBF_CLR_TRQ        1
`define CMBF_CLR_DN         2
`define CMBF_CLR_IE         3
`define CMBF_CLR_MOW        4
`define CMBF_SET_RDY        8
`define CMBF_SET_TRQ        9
`define CMBF_SET_DN         10
`define CMBF_SET_IE         11
// read flag positions
`define CMBF_F_RDY          0
`define CMBF_F_TRQ          1
`define CMBF_F_DN           2
`define CMBF_F_IE           3
`define CMBF_F_MOW          4
// mode register fields
`define CMBF_MODE_TYPE_LSB  0
`define CMBF_MODE_TYPE_MSB  2
`define CMBF_MODE_LISTEN    3
// interrupt status bits
`define CMBF_IRQ_TX         0
`define CMBF_IRQ_RX         1
`define CMBF_IRQ_LRX        2
`define CMBF_IRQ_W          3
// buffer types
`define CMBF_TYPE_TX        3'h0
`define CMBF_TYPE_RX_LO     3'h1
`define CMBF_TYPE_RX_HI     3'h5
// listening channel buffer range
`define CMBF_LISTEN_LO      6'h20
`define CMBF_LISTEN_HI      6'h2f
// reset values
`define CMBF_RST_FLAGS      5'h00
`define CMBF_RST_MODE       4'h1
`endif

/* File: hw/cmbf_sync.v */
// cmbf_sync.v - two flop synchroniser for one level
// assumes: din comes from outside the pclk domain
`timescale 1ns/1ps
`default_nettype none
module cmbf_sync (
  input  wire pclk,
  input  wire presetn,
  input  wire din,
  output reg  dout
);
  reg meta_r;

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      meta_r <= 1'b0;
      dout   <= 1'b0;
    end else begin
      meta_r <= din;
      dout   <= meta_r;
    end
  end
endmodule // cmbf_sync
`default_nettype wire

/* File: hw/cmbf_irq.v */
// cmbf_irq.v - sticky interrupt status, enable mask and level output
// assumes: set pulses and clear writes on pclk; set wins over clear
`timescale 1ns/1ps
`default_nettype none
module cmbf_irq #(
  parameter W = 3
) (
  input  wire         pclk,
  input  wire         presetn,
  input  wire [W-1:0] set_pls,
  input  wire [W-1:0] clr_pls,
  input  wire [W-1:0] wr_en_val,
  input  wire         wr_en,
  output reg  [W-1:0] status,
  output reg  [W-1:0] enable,
  output reg          irq
);
  genvar i;
  generate
    for (i = 0; i < W; i = i + 1) begin : g_bit
      always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          status[i] <= 1'b0;
        end else if (set_pls[i]) begin
          status[i] <= 1'b1;
        end else if (clr_pls[i]) begin
          status[i] <= 1'b0;
        end
      end
    end
  endgenerate

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      enable <= {W{1'b0}};
      irq    <= 1'b0;
    end else begin
      if (wr_en) begin
        enable <= wr_en_val;
      end
      irq <= |((status | set_pls) & ~(clr_pls & ~set_pls) & (wr_en ? wr_en_val : enable));
    end
  end
endmodule // cmbf_irq
`default_nettype wire

/* File: hw/cmbf_top.v */
// cmbf_top.v - control flags of one can message buffer behind apb
// assumes: engine event inputs are one-cycle pulses on pclk; mode pins asynchronous
// How it works
// - ie=1, type 000: successful transmit raises transmit-done status event
// - ie=1: data frame into type 001-101, or remote into 000, raises receive event
// - listen mode, ie=1, buffers 32-47: reception sets listener receive status
// - storing a data frame over unread contents sets overwrite flag
// - remote frame into transmit buffer with data-new set leaves overwrite unchanged
// - listen mode: overwrite clear ignored while listener receives into buffer
// - ready=1: host writes ignored except ready, request, data-new, overwrite flags, irq clear and irq enable
//
// The APB register port and the address map were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
`include "cmbf_defs.vh"
module cmbf_top #(
  parameter [5:0] BUF_INDEX = 6'h20
) (
  input  wire        pclk,
  input  wire        presetn,
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [11:0] paddr,
  input  wire [31:0] pwdata,
  output reg  [31:0] prdata,
  output wire        pready,
  output wire        pslverr,
  input  wire        tx_done_pulse,
  input  wire        tx_is_remote,
  input  wire        tx_active,
  input  wire        rx_store_pulse,
  input  wire        rx_is_remote,
  input  wire        rx_from_listener,
  input  wire        listener_busy,
  input  wire        mirror_mode_pin,
  output wire        buffer_ready,
  output wire        transmit_request,
  output wire        data_new_flag,
  output wire        overwrite_flag,
  output wire        buffer_irq_enable,
  output wire [2:0]  buffer_type,
  output wire [31:0] payload,
  output wire        tx_done_status,
  output wire        rx_done_status,
  output wire        listener_irq_status,
  output wire        irq
);
  reg  [4:0]  flags_r;
  reg  [4:0]  flags_nxt;
  reg  [3:0]  mode_r;
  reg  [31:0] payload_r;
  wire        mode_sync;
  wire        listen_mode;
  wire        wr_acc;
  wire        rd_acc;
  wire        cmd_wr;
  wire        rdy;
  wire        type_tx;
  wire        type_rx;
  wire        in_range;
  wire        ev_tx;
  wire        ev_rx;
  wire        ev_lrx;
  wire [2:0]  irq_stat;
  wire [2:0]  irq_en;
  wire        clr_mow_ok;

  cmbf_sync u_sync (
    .pclk    (pclk),
    .presetn (presetn),
    .din     (mirror_mode_pin),
    .dout    (mode_sync)
  );

  assign pready  = 1'b1;
  assign wr_acc  = psel & penable & pwrite;
  assign rd_acc  = psel & penable & ~pwrite;
  assign cmd_wr  = wr_acc & (paddr == `CMBF_ADDR_CTRL_WR);
  assign pslverr = psel & penable & ~(paddr == `CMBF_ADDR_CTRL_WR ||
                   paddr == `CMBF_ADDR_CTRL_RD || paddr == `CMBF_ADDR_MODE ||
                   paddr == `CMBF_ADDR_IRQ_STAT || paddr == `CMBF_ADDR_IRQ_CLR ||
                   paddr == `CMBF_ADDR_IRQ_EN || paddr == `CMBF_ADDR_PAYLOAD);

  assign rdy         = flags_r[`CMBF_F_RDY];
  assign listen_mode = mode_r[`CMBF_MODE_LISTEN] | mode_sync;
  assign buffer_type = mode_r[`CMBF_MODE_TYPE_MSB:`CMBF_MODE_TYPE_LSB];
  assign type_tx     = (buffer_type == `CMBF_TYPE_TX);
  assign type_rx     = (buffer_type >= `CMBF_TYPE_RX_LO) && (buffer_type <= `CMBF_TYPE_RX_HI);
  assign in_range    = (BUF_INDEX >= `CMBF_LISTEN_LO) && (BUF_INDEX <= `CMBF_LISTEN_HI);

  // interrupt events gated by the buffer enable
  assign ev_tx  = tx_done_pulse & flags_r[`CMBF_F_IE] & type_tx;
  assign ev_rx  = rx_store_pulse & ~rx_from_listener & flags_r[`CMBF_F_IE] &
                  ((type_rx & ~rx_is_remote) | (type_tx & rx_is_remote));
  assign ev_lrx = rx_store_pulse & rx_from_listener & listen_mode & in_range &
                  flags_r[`CMBF_F_IE];

  // overwrite clear blocked while listener is filling the buffer
  assign clr_mow_ok = ~(listen_mode & listener_busy);

  always @* begin
    flags_nxt = flags_r;
    if (cmd_wr) begin
      // each command bit only moves its own flag
      if (pwdata[`CMBF_CLR_RDY] & ~tx_active) flags_nxt[`CMBF_F_RDY] = 1'b0;
      if (pwdata[`CMBF_SET_RDY]) flags_nxt[`CMBF_F_RDY] = 1'b1;
      if (pwdata[`CMBF_CLR_TRQ]) flags_nxt[`CMBF_F_TRQ] = 1'b0;
      if (pwdata[`CMBF_SET_TRQ]) flags_nxt[`CMBF_F_TRQ] = 1'b1;
      if (pwdata[`CMBF_CLR_DN]) flags_nxt[`CMBF_F_DN] = 1'b0;
      if (pwdata[`CMBF_SET_DN]) flags_nxt[`CMBF_F_DN] = 1'b1;
      if (pwdata[`CMBF_CLR_MOW] & clr_mow_ok) flags_nxt[`CMBF_F_MOW] = 1'b0;
      // ie is part of buffer setup, frozen while ready
      if (!rdy) begin
        if (pwdata[`CMBF_CLR_IE]) flags_nxt[`CMBF_F_IE] = 1'b0;
        if (pwdata[`CMBF_SET_IE]) flags_nxt[`CMBF_F_IE] = 1'b1;
      end
    end
    // engine updates win over host commands
    if (tx_done_pulse) flags_nxt[`CMBF_F_TRQ] = 1'b0;
    if (rx_store_pulse) begin
      if (!(rx_is_remote & type_tx) & flags_r[`CMBF_F_DN] & ~rx_is_remote)
        flags_nxt[`CMBF_F_MOW] = 1'b1;
      flags_nxt[`CMBF_F_DN] = 1'b1;
      if (rx_is_remote & type_tx) flags_nxt[`CMBF_F_TRQ] = 1'b1;
    end
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      flags_r   <= `CMBF_RST_FLAGS;
      mode_r    <= `CMBF_RST_MODE;
      payload_r <= 32'h0000_0000;
    end else begin
      flags_r <= flags_nxt;
      if (wr_acc && !rdy) begin
        if (paddr == `CMBF_ADDR_MODE) mode_r <= pwdata[3:0];
        if (paddr == `CMBF_ADDR_PAYLOAD) payload_r <= pwdata;
      end
    end
  end

  cmbf_irq #(
    .W (3)
  ) u_irq (
    .pclk      (pclk),
    .presetn   (presetn),
    .set_pls   ({ev_lrx, ev_rx, ev_tx}),
    .clr_pls   ((wr_acc && paddr == `CMBF_ADDR_IRQ_CLR) ? pwdata[2:0] : 3'h0),
    .wr_en_val (pwdata[2:0]),
    .wr_en     (wr_acc && paddr == `CMBF_ADDR_IRQ_EN),
    .status    (irq_stat),
    .enable    (irq_en),
    .irq       (irq)
  );

  assign tx_done_status      = irq_stat[`CMBF_IRQ_TX];
  assign rx_done_status      = irq_stat[`CMBF_IRQ_RX];
  assign listener_irq_status = irq_stat[`CMBF_IRQ_LRX];

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
    end else if (psel && !penable && !pwrite) begin
      case (paddr)
        `CMBF_ADDR_CTRL_RD:  prdata <= {27'h0, flags_r};
        `CMBF_ADDR_MODE:     prdata <= {28'h0, mode_r};
        `CMBF_ADDR_IRQ_STAT: prdata <= {29'h0, irq_stat};
        `CMBF_ADDR_IRQ_EN:   prdata <= {29'h0, irq_en};
        `CMBF_ADDR_PAYLOAD:  prdata <= payload_r;
        default:             prdata <= 32'h0000_0000;
      endcase
    end
  end

  assign buffer_ready      = flags_r[`CMBF_F_RDY];
  assign transmit_request  = flags_r[`CMBF_F_TRQ];
  assign data_new_flag     = flags_r[`CMBF_F_DN];
  assign overwrite_flag    = flags_r[`CMBF_F_MOW];
  assign buffer_irq_enable = flags_r[`CMBF_F_IE];
  assign payload           = payload_r;
  // frame kind of a finished transmission does not change the flag handling
  wire unused_ok = rd_acc | tx_is_remote;
endmodule // cmbf_top
`default_nettype wire

/* File: dv/cmbf_top_properties.sv */
// cmbf checker: flag and status relations at the block ports
// assumes: bound into cmbf_top, engine events are one-cycle pulses
`timescale 1ns/1ps
`default_nettype none
`include "cmbf_defs.vh"
module cmbf_top_properties (
  input wire logic        pclk, presetn, psel, penable, pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata, payload,
  input wire logic [2:0]  buffer_type,
  input wire logic        buffer_ready, data_new_flag, overwrite_flag, buffer_irq_enable,
  input wire logic        tx_done_pulse, rx_store_pulse, rx_is_remote, rx_from_listener,
  input wire logic        listener_busy, mirror_mode_pin, tx_done_status, rx_done_status,
  input wire logic        listener_irq_status
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  wire wr  = psel && penable && pwrite;
  wire ie  = buffer_irq_enable;
  wire dst = rx_store_pulse && !rx_is_remote;
  // listen mode is trusted once the pin has passed the synchroniser
  sequence s_mir;
    mirror_mode_pin [*4];
  endsequence
  sequence s_ctl_wr;
    wr && paddr == `CMBF_ADDR_CTRL_WR;
  endsequence
  property p_tx;
    tx_done_pulse && ie && buffer_type == 3'h0 |=> tx_done_status;
  endproperty
  a_tx: assert property (p_tx) else $error("tx status missing");
  property p_rx;
    rx_store_pulse && ie && !rx_from_listener &&
    (dst ? (buffer_type >= 3'h1 && buffer_type <= 3'h5) : buffer_type == 3'h0)
    |=> rx_done_status;
  endproperty
  a_rx: assert property (p_rx) else $error("rx status missing");
  property p_lrx;
    s_mir ##0 (rx_store_pulse && rx_from_listener && ie) |=> listener_irq_status;
  endproperty
  a_lrx: assert property (p_lrx) else $error("listener status missing");
  property p_ovw;
    dst && data_new_flag |=> overwrite_flag;
  endproperty
  a_ovw: assert property (p_ovw) else $error("overwrite not set");
  property p_rem;
    rx_store_pulse && rx_is_remote && buffer_type == 3'h0 && !wr |=> $stable(overwrite_flag);
  endproperty
  a_rem: assert property (p_rem) else $error("remote frame moved overwrite");
  property p_lclr;
    s_mir ##0 (s_ctl_wr ##0 (pwdata[4] && listener_busy && overwrite_flag)) |=> overwrite_flag;
  endproperty
  a_lclr: assert property (p_lclr) else $error("overwrite cleared while busy");
  property p_lock;
    wr && buffer_ready && (paddr == `CMBF_ADDR_MODE || paddr == `CMBF_ADDR_PAYLOAD)
    |=> $stable(buffer_type) && $stable(payload);
  endproperty
  a_lock: assert property (p_lock) else $error("locked buffer written");
  property p_only;
    s_ctl_wr ##0 (!pwdata[2] && !pwdata[10] && !rx_store_pulse) |=> $stable(data_new_flag);
  endproperty
  a_only: assert property (p_only) else $error("untargeted flag moved");
endmodule // cmbf_top_properties
bind cmbf_top cmbf_top_properties i_cmbf_top_properties (.*);
`default_nettype wire

/* File: dv/cmbf_engine_model.sv */
// cmbf engine model: one transmit or receive event per go request
// assumes: go is a one-cycle request on pclk, dly sets the answer delay
`timescale 1ns/1ps
`default_nettype none
module cmbf_engine_model (
  input  wire logic       pclk,
  input  wire logic       presetn,
  input  wire logic       go,
  input  wire logic [1:0] kind,
  input  wire logic       lsn,
  input  wire logic [3:0] dly,
  output var  logic       busy,
  output wire logic       tx_active,
  output wire logic       tx_done_pulse,
  output wire logic       tx_is_remote,
  output wire logic       rx_store_pulse,
  output wire logic       rx_is_remote,
  output wire logic       rx_from_listener,
  output wire logic       listener_busy
);
  logic [3:0] cnt_r;
  logic [1:0] kind_r;
  logic       lsn_r;
  wire        fire = busy && cnt_r == 4'h0;
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      {busy, cnt_r, kind_r, lsn_r} <= 8'h00;
    end else if (go && !busy) begin
      {busy, cnt_r, kind_r, lsn_r} <= {1'b1, dly, kind, lsn};
    end else if (fire) begin
      busy <= 1'b0;
    end else if (busy) begin
      cnt_r <= cnt_r - 4'h1;
    end
  end
  // qualifiers show the inverse value outside the event cycle
  assign tx_active        = busy && !kind_r[1];
  assign tx_done_pulse    = fire && !kind_r[1];
  assign rx_store_pulse   = fire && kind_r[1];
  assign tx_is_remote     = fire ? kind_r[0] : !kind_r[0];
  assign rx_is_remote     = fire ? kind_r[0] : !kind_r[0];
  assign rx_from_listener = fire ? lsn_r : !lsn_r;
  assign listener_busy    = busy && kind_r[1] && lsn_r;
endmodule // cmbf_engine_model
`default_nettype wire

/* File: dv/cmbf_top_tb_top.sv */
// cmbf bench: apb host tasks and engine scenarios
// assumes: cmbf_engine_model drives the engine pins
`timescale 1ns/1ps
`default_nettype none
`include "cmbf_defs.vh"
module cmbf_top_tb_top;
  localparam [11:0] CW = `CMBF_ADDR_CTRL_WR, CR = `CMBF_ADDR_CTRL_RD, MD = `CMBF_ADDR_MODE;
  localparam [11:0] IS = `CMBF_ADDR_IRQ_STAT, IE = `CMBF_ADDR_IRQ_EN;
  logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
  logic        mirror_mode_pin = 0, go = 0, lsn = 0, err;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, rdata;
  logic [1:0]  kind = 2'h0;
  logic [3:0]  dly = 4'h0;
  wire  [31:0] prdata, payload;
  wire  [2:0]  buffer_type;
  wire         pready, pslverr, tx_done_pulse, tx_is_remote, tx_active, rx_store_pulse;
  wire         rx_is_remote, rx_from_listener, listener_busy, buffer_ready, transmit_request;
  wire         data_new_flag, overwrite_flag, buffer_irq_enable, tx_done_status;
  wire         rx_done_status, listener_irq_status, irq, busy;
  int          n_fail = 0, check_count = 0, i;
  always #50 pclk = ~pclk;
  cmbf_top i_cmbf_top (.*);
  cmbf_engine_model i_cmbf_engine_model (.*);
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] s);
    check_count++;
    if (s !== e) begin
      n_fail++;
      $display("wrong value %s expected %h seen %h", nm, e, s);
    end
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rdata = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rd(input logic [11:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk($sformatf("reg %h", a), e, rdata);
  endtask
  task automatic eng_go(input logic [1:0] k, input logic l, input logic [3:0] d);
    @(posedge pclk);
    go <= 1'b1;
    kind <= k;
    lsn <= l;
    dly <= d;
    @(posedge pclk);
    go <= 1'b0;
  endtask
  task automatic eng_wait;
    for (i = 0; i < 30; i++) begin
      @(negedge pclk);
      if (busy !== 1'b1) break;
    end
    chk("engine idle", 32'h0, {31'h0, busy});
    repeat (2) @(posedge pclk);
    @(negedge pclk);
  endtask
  task automatic eng(input logic [1:0] k, input logic [3:0] d);
    eng_go(k, 1'b0, d);
    eng_wait;
  endtask
  task automatic t_tx;
    rd(CR, 32'h0);
    rd(MD, 32'h1);
    rd(12'h01c, 32'h0);
    chk("pslverr", 32'h1, {31'h0, err});
    apb(1'b1, MD, 32'h0);
    apb(1'b1, IE, 32'h7);
    apb(1'b1, CW, 32'h1 << `CMBF_SET_IE);
    apb(1'b1, CW, 32'h1 << `CMBF_SET_RDY);
    apb(1'b1, CW, 32'h1 << `CMBF_SET_TRQ);
    apb(1'b1, MD, 32'h5);
    apb(1'b1, `CMBF_ADDR_PAYLOAD, 32'h5a);
    rd(CR, 32'h0b);
    chk("type and payload", 32'h0, payload | buffer_type);
    eng(2'h0, 4'h3); // no ready clear during the transmission
    rd(CR, 32'h09);
    chk("tx status and irq", 32'h3, {30'h0, irq, tx_done_status});
    apb(1'b1, IE, 32'h0);
    @(posedge pclk);
    @(negedge pclk);
    chk("masked irq", 32'h0, {31'h0, irq});
    apb(1'b1, `CMBF_ADDR_IRQ_CLR, 32'h7);
    rd(IS, 32'h0);
    apb(1'b1, IE, 32'h7);
    for (i = 0; i < 4; i++) begin
      apb(1'b1, CW, 32'h1 << `CMBF_CLR_RDY);
      apb(1'b0, CR, 32'h0);
      if (rdata[`CMBF_F_RDY] === 1'b0) break;
    end
    chk("flags", 32'h08, rdata);
  endtask
  task automatic t_rx;
    apb(1'b1, MD, 32'h1);
    eng(2'h2, 4'h0); // data-new here is raised by the engine, not by a host write
    rd(CR, 32'h0c);
    rd(IS, 32'h2);
    eng(2'h2, 4'h5);
    rd(CR, 32'h1c);
    apb(1'b1, CW, 32'h1 << `CMBF_CLR_MOW);
    rd(CR, 32'h0c);
    apb(1'b1, MD, 32'h0);
    eng(2'h3, 4'h1);
    rd(CR, 32'h0e);
    apb(1'b1, CW, 32'h06);
  endtask
  task automatic t_lsn;
    mirror_mode_pin <= 1'b1;
    apb(1'b1, MD, 32'h1);
    eng(2'h2, 4'h0);
    eng(2'h2, 4'h0);
    eng_go(2'h2, 1'b1, 4'h8);
    apb(1'b1, CW, 32'h1 << `CMBF_CLR_MOW);
    rd(CR, 32'h1c);
    eng_wait;
    chk("listener status", 32'h1, {31'h0, listener_irq_status});
    for (i = 0; i < 4; i++) begin
      apb(1'b1, CW, 32'h14);
      apb(1'b0, CR, 32'h0);
      if (rdata[`CMBF_F_MOW] === 1'b0) break;
    end
    chk("flags", 32'h08, rdata);
  endtask
  task automatic conclude;
    $display("checks %0d failures %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  initial begin
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    t_tx;
    t_rx;
    t_lsn;
    conclude;
  end
  initial begin
    #200000;
    n_fail++;
    conclude;
  end
endmodule // cmbf_top_tb_top
`default_nettype wire
